/* aie_regs.svh */
`ifndef AIE_REGS_SVH
`define AIE_REGS_SVH

// Register byte offsets on the APB bus.
`define AIE_OFF_INSTR 8'h00
`define AIE_OFF_WORK 8'h04
`define AIE_OFF_STAT 8'h08
`define AIE_OFF_FADDR 8'h0C
`define AIE_OFF_FDATA 8'h10
`define AIE_OFF_PC 8'h14
`define AIE_OFF_DIR 8'h18
`define AIE_OFF_PIN 8'h1C
`define AIE_OFF_CFG 8'h20

// Status register field positions.
`define AIE_STAT_C 0
`define AIE_STAT_DC 1
`define AIE_STAT_Z 2
`define AIE_STAT_BUSY 3

// Opcode patterns.
`define AIE_OP_ADD_WORK 6'h07
`define AIE_OP_AND_FILE 6'h05
`define AIE_OP_AND_LIT 4'hE
`define AIE_OP_BRANCH 3'h5
`define AIE_OP_DIR_LOAD 9'h000

// Special file addresses.
`define AIE_F_TMR 5'h01
`define AIE_F_PCL 5'h02
`define AIE_F_PORT_LO 3'h5

// Reset values.
`define AIE_DIR_RST 8'hFF

// Oscillator periods per instruction cycle, and the last phase count.
`define AIE_OSC_PER_CYC 4
`define AIE_PHASE_LAST 2'h3

`endif

/* aie_pkg.sv */
package aie_pkg;

  typedef enum logic [1:0] {
    AIE_IDLE = 2'b00,
    AIE_EXEC = 2'b01,
    AIE_FLUSH = 2'b11
  } aie_state_t;

  typedef struct packed {
    aie_state_t st;
    logic [11:0] ir;
    logic [7:0] w;
    logic c;
    logic dc;
    logic z;
    logic [8:0] pc;
    logic [31:0][7:0] file;
    logic [2:0][7:0] dir;
    logic [4:0] faddr;
    logic presc_asg;
    logic presc_clr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } aie_core_t;

  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic dc;
    logic z;
  } aie_alu_t;

  typedef struct packed {
    logic [1:0] cnt;
  } aie_div_t;

  typedef struct packed {
    logic [23:0] out;
    logic [23:0] oe_n;
  } aie_pins_t;

endpackage

/* aie_alu.sv */
`timescale 1ns/1ns
`include "aie_regs.svh"
module aie_alu import aie_pkg::*; (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic add,
  output aie_alu_t y
);
  logic [4:0] lo;
  logic [8:0] sum;

  always_comb begin
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    sum = {1'b0, a} + {1'b0, b};
    y.res = add ? sum[7:0] : (a & b);
    y.c = sum[8];
    y.dc = lo[4];
    y.z = (y.res == 8'h00);
  end
endmodule

/* aie_osc_div.sv */
`timescale 1ns/1ns
`include "aie_regs.svh"
module aie_osc_div import aie_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic tick
);
  aie_div_t q;
  aie_div_t n;

  // Counts the oscillator periods of one instruction cycle while busy.
  always_comb begin
    n = q;
    if (!run) begin
      n.cnt = 2'h0;
    end else begin
      n.cnt = q.cnt + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tick = run && (q.cnt == `AIE_PHASE_LAST);
endmodule

/* aie_core.sv */
// Overview of operation
// - Instructions writing the program counter clear its ninth bit, except branches.
// - Read-modify-write of an I/O port takes the pin levels as operand.
// - Direction load with file 5, 6 or 7 copies work into that port's direction latch.
// - A direction latch one turns the pin driver off.
// - File op on the timer with destination one clears an assigned prescaler.
// - Opcode 0001 11df ffff adds work and file, updating all three flags.
// - Destination bit zero puts the result in work, file left alone.
// - Destination bit one writes the result back to the file register.
// - Opcode 0001 01df ffff ANDs work with file, updating only Z.
// - Opcode 1110 kkkk kkkk ANDs work with literal into work, updating Z.
// - One cycle is four periods; program counter changes take two cycles.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "aie_regs.svh"
module aie_core import aie_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [23:0] pin_in,
  output aie_pins_t pins,
  output logic presc_clr
);
  aie_core_t q;
  aie_core_t n;
  aie_alu_t y;
  logic tick;
  logic exe;
  logic [4:0] f;
  logic dbit;
  logic is_add;
  logic is_and_work_with_file;
  logic is_and_literal_with_work;
  logic is_br;
  logic is_dirld;
  logic is_fop;
  logic fwr;
  logic pc_wr;
  logic two;
  logic [7:0] opnd;
  logic [1:0] dir_idx;

  // Port registers read the pins, the low program counter reads itself.
  function automatic logic [7:0] rd_f(input logic [4:0] a);
    logic [7:0] v;
    v = q.file[a];
    if (a == `AIE_F_PCL) begin
      v = q.pc[7:0];
    end else if (a[4:3] == 2'b00 && a[2:0] >= `AIE_F_PORT_LO) begin
      v = pin_in[8 * (a[1:0] - 2'b01) +: 8];
    end
    return v;
  endfunction

  aie_osc_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(q.st != AIE_IDLE),
    .tick(tick)
  );

  assign f = q.ir[4:0];
  assign dbit = q.ir[5];
  assign is_add = (q.ir[11:6] == `AIE_OP_ADD_WORK);
  assign is_and_work_with_file = (q.ir[11:6] == `AIE_OP_AND_FILE);
  assign is_and_literal_with_work = (q.ir[11:8] == `AIE_OP_AND_LIT);
  assign is_br = (q.ir[11:9] == `AIE_OP_BRANCH);
  assign is_dirld = (q.ir[11:3] == `AIE_OP_DIR_LOAD) &&
                    (q.ir[2:0] >= `AIE_F_PORT_LO);
  assign dir_idx = 2'(q.ir[2:0] - `AIE_F_PORT_LO);
  assign is_fop = is_add || is_and_work_with_file;
  assign fwr = is_fop && dbit;
  assign pc_wr = fwr && (f == `AIE_F_PCL);
  assign two = is_br || pc_wr;
  assign opnd = is_and_literal_with_work ? q.ir[7:0] : rd_f(f);
  assign exe = (q.st == AIE_EXEC) && tick;

  aie_alu u_alu (
    .a(q.w),
    .b(opnd),
    .add(is_add),
    .y(y)
  );

  always_comb begin
    n = q;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.presc_clr = 1'b0;
    unique case (q.st)
      AIE_IDLE: begin
      end
      AIE_EXEC: begin
        if (exe) begin
          n.pc = q.pc + 9'h001;
          if (is_fop || is_and_literal_with_work) begin
            n.z = y.z;
            if (is_add) begin
              n.c = y.c;
              n.dc = y.dc;
            end
            if (fwr) begin
              if (f == `AIE_F_PCL) begin
                n.pc = {1'b0, y.res};
              end else begin
                n.file[f] = y.res;
              end
            end else begin
              n.w = y.res;
            end
          end
          if (fwr && f == `AIE_F_TMR && q.presc_asg) begin
            n.presc_clr = 1'b1;
          end
          if (is_br) begin
            n.pc = q.ir[8:0];
          end
          if (is_dirld) begin
            n.dir[dir_idx] = q.w;
          end
          n.st = two ? AIE_FLUSH : AIE_IDLE;
        end
      end
      AIE_FLUSH: begin
        if (tick) begin
          n.st = AIE_IDLE;
        end
      end
    endcase
    // Writes stall with pready low while an instruction is running.
    if (psel && penable && !q.pready &&
        !(pwrite && q.st != AIE_IDLE)) begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      unique case (paddr)
        `AIE_OFF_INSTR: begin
          n.prdata = {20'h0_0000, q.ir};
          if (pwrite) begin
            n.ir = pwdata[11:0];
            n.st = AIE_EXEC;
          end
        end
        `AIE_OFF_WORK: begin
          n.prdata = {24'h00_0000, q.w};
          if (pwrite) begin
            n.w = pwdata[7:0];
          end
        end
        `AIE_OFF_STAT: begin
          n.prdata = {28'h000_0000, q.st != AIE_IDLE, q.z, q.dc, q.c};
          if (pwrite) begin
            n.c = pwdata[`AIE_STAT_C];
            n.dc = pwdata[`AIE_STAT_DC];
            n.z = pwdata[`AIE_STAT_Z];
          end
        end
        `AIE_OFF_FADDR: begin
          n.prdata = {27'h000_0000, q.faddr};
          if (pwrite) begin
            n.faddr = pwdata[4:0];
          end
        end
        `AIE_OFF_FDATA: begin
          n.prdata = {24'h00_0000, rd_f(q.faddr)};
          if (pwrite) begin
            if (q.faddr == `AIE_F_PCL) begin
              n.pc = {1'b0, pwdata[7:0]};
            end else begin
              n.file[q.faddr] = pwdata[7:0];
            end
          end
        end
        `AIE_OFF_PC: begin
          n.prdata = {23'h00_0000, q.pc};
          if (pwrite) begin
            n.pc = pwdata[8:0];
          end
        end
        `AIE_OFF_DIR: begin
          n.prdata = {8'h00, q.dir};
          if (pwrite) begin
            n.dir = pwdata[23:0];
          end
        end
        `AIE_OFF_PIN: begin
          n.prdata = {8'h00, pin_in};
        end
        `AIE_OFF_CFG: begin
          n.prdata = {31'h0000_0000, q.presc_asg};
          if (pwrite) begin
            n.presc_asg = pwdata[0];
          end
        end
        default: begin
          n.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.dir <= {3{`AIE_DIR_RST}};
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign presc_clr = q.presc_clr;

  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_port
    assign pins.out[8 * gi +: 8] = q.file[5 + gi];
    assign pins.oe_n[8 * gi +: 8] = q.dir[gi];
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_pc_ninth_clr: assert property (
    exe && pc_wr |=> !q.pc[8] && q.pc[7:0] == $past(y.res))
    else $error("Program counter ninth bit not cleared.");

  chk_branch_keep: assert property (
    exe && is_br |=> q.pc == $past(q.ir[8:0]))
    else $error("Branch target not loaded whole.");

  chk_pin_operand: assert property (
    exe && is_add && !dbit && f == 5'h05
    |=> q.w == 8'($past(q.w) + $past(pin_in[7:0])))
    else $error("Port operand not taken from pins.");

  chk_dir_load: assert property (
    exe && is_dirld && q.ir[2:0] == 3'h6 |=> q.dir[1] == $past(q.w))
    else $error("Direction latch not loaded from work.");

  chk_hiz_pin: assert property (
    exe && is_dirld && q.ir[2:0] == 3'h5 && q.w[0] |=> pins.oe_n[0])
    else $error("Pin still driven after direction one.");

  chk_presc_clear: assert property (
    exe && fwr && f == 5'h01 && q.presc_asg |=> presc_clr ##1 !presc_clr)
    else $error("Prescaler clear pulse missing.");

  chk_add_carry: assert property (
    exe && is_add && !dbit
    |=> {q.c, q.w} == {1'b0, $past(q.w)} + {1'b0, $past(opnd)})
    else $error("Add result or carry wrong.");

  chk_dest_work: assert property (
    exe && is_fop && !dbit && f == 5'h03 |=> $stable(q.file[3]))
    else $error("File changed with work destination.");

  chk_dest_file: assert property (
    exe && is_and_work_with_file && dbit && f == 5'h03
    |=> q.file[3] == ($past(q.w) & $past(q.file[3])) && $stable(q.w))
    else $error("File write-back wrong.");

  chk_and_flags: assert property (
    exe && is_and_work_with_file |=> $stable(q.c) && $stable(q.dc))
    else $error("AND changed a carry flag.");

  chk_and_literal_with_work_zero: assert property (
    exe && is_and_literal_with_work
    |=> q.w == ($past(q.w) & $past(q.ir[7:0])) && q.z == (q.w == 8'h00))
    else $error("AND literal result or zero flag wrong.");

  chk_one_cycle: assert property (
    $rose(q.st == AIE_EXEC) && !two
    |-> (q.st == AIE_EXEC)[*4] ##1 q.st == AIE_IDLE)
    else $error("Single-cycle instruction not four periods.");

  chk_two_cycle: assert property (
    $rose(q.st == AIE_EXEC) && two
    |-> ##4 (q.st == AIE_FLUSH)[*4] ##1 q.st == AIE_IDLE)
    else $error("Two-cycle instruction not eight periods.");

  cov_add: cover property (exe && is_add);
  cov_branch: cover property (exe && is_br);
  cov_dirld: cover property (exe && is_dirld);
  cov_presc: cover property (presc_clr);
endmodule

/* alu_instruction_execute_tb.sv */
`timescale 1ns/1ns
`include "aie_regs.svh"
module alu_instruction_execute_tb import aie_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [23:0] pin_in = 24'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic presc_clr;
  aie_pins_t pins;
  int n_fail = 0;
  int n_compared = 0;
  int n_presc = 0;
  logic [32:0] q[$];
  logic [7:0] w, fv, r, k, p;
  logic [4:0] f, t;
  logic [2:0] fl;
  logic [23:0] dexp;
  logic [31:0] cfg = 32'h0;
  logic c, dc, z, d, op;

  always #20 pclk = ~pclk;

  aie_core i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .pin_in(pin_in),
    .pins(pins),
    .presc_clr(presc_clr)
  );

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The monitor pairs each completed read with the oldest expectation.
  always @(posedge pclk) begin
    if (presc_clr === 1'b1) n_presc++;
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
      chk({pslverr, prdata}, q.pop_front());
    end
  end

  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] dv);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dv;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_fail++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    xfer(1'b1, a, dv);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back({1'b0, e});
    xfer(1'b0, a, 32'h0);
  endtask

  // Configuration goes in first; the trailing write stalls until done.
  task automatic exec(input logic [11:0] ins);
    wr(`AIE_OFF_CFG, cfg);
    wr(`AIE_OFF_INSTR, {20'h0, ins});
    wr(`AIE_OFF_CFG, cfg);
  endtask

  task automatic end_sim;
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    end_sim();
  end

  initial begin
    void'($urandom(10275));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    dexp = 24'hFFFFFF;
    rd(`AIE_OFF_DIR, {8'h0, dexp});
    q.push_back({1'b1, 32'h0});
    xfer(1'b0, 8'h40, 32'h0);
    for (int i = 0; i < 6; i++) begin
      w = 8'($urandom);
      fv = 8'($urandom);
      f = 5'd8 + 5'($urandom % 24);
      d = 1'($urandom);
      fl = 3'($urandom);
      op = ~i[0];
      if (i == 0) begin
        w = 8'hFF;
        fv = 8'h01;
      end
      if (i == 5) f = 5'd31;
      c = fl[0];
      dc = fl[1];
      if (op) begin
        {c, r} = {1'b0, w} + {1'b0, fv};
        t = {1'b0, w[3:0]} + {1'b0, fv[3:0]};
        dc = t[4];
      end else begin
        r = w & fv;
      end
      z = (r == 8'h00);
      wr(`AIE_OFF_WORK, {24'h0, w});
      wr(`AIE_OFF_FADDR, {27'h0, f});
      wr(`AIE_OFF_FDATA, {24'h0, fv});
      wr(`AIE_OFF_STAT, {29'h0, fl});
      exec(op ? {`AIE_OP_ADD_WORK, d, f} : {`AIE_OP_AND_FILE, d, f});
      rd(`AIE_OFF_WORK, {24'h0, d ? w : r});
      rd(`AIE_OFF_FDATA, {24'h0, d ? r : fv});
      rd(`AIE_OFF_STAT, {29'h0, z, dc, c});
    end
    for (int i = 0; i < 3; i++) begin
      w = 8'($urandom);
      k = (i == 0) ? 8'h00 : 8'($urandom);
      wr(`AIE_OFF_WORK, {24'h0, w});
      wr(`AIE_OFF_STAT, 32'h3);
      exec({`AIE_OP_AND_LIT, k});
      rd(`AIE_OFF_WORK, {24'h0, w & k});
      rd(`AIE_OFF_STAT, {29'h0, (w & k) == 8'h00, 2'b11});
    end
    for (int i = 0; i < 3; i++) begin
      w = 8'($urandom);
      dexp[i*8 +: 8] = w;
      wr(`AIE_OFF_WORK, {24'h0, w});
      exec(12'h005 + 12'(i));
      rd(`AIE_OFF_DIR, {8'h0, dexp});
      chk({9'h0, pins.oe_n}, {9'h0, dexp});
    end
    p = 8'($urandom) & 8'h7E;
    pin_in <= {8'h00, p, 8'h00};
    wr(`AIE_OFF_FADDR, 32'h6);
    wr(`AIE_OFF_FDATA, 32'hFF);
    wr(`AIE_OFF_WORK, 32'hFF);
    exec({`AIE_OP_AND_FILE, 1'b1, 5'd6});
    chk({25'h0, pins.out[15:8]}, {25'h0, p});
    cfg = 32'h1;
    wr(`AIE_OFF_FADDR, 32'h1);
    wr(`AIE_OFF_WORK, 32'h3);
    exec({`AIE_OP_ADD_WORK, 1'b1, `AIE_F_TMR});
    exec({`AIE_OP_AND_FILE, 1'b1, `AIE_F_TMR});
    exec({`AIE_OP_ADD_WORK, 1'b0, `AIE_F_TMR});
    cfg = 32'h0;
    exec({`AIE_OP_ADD_WORK, 1'b1, `AIE_F_TMR});
    repeat (4) @(posedge pclk);
    chk(33'(n_presc), 33'd2);
    wr(`AIE_OFF_PC, 32'h1F0);
    wr(`AIE_OFF_FADDR, 32'h2);
    wr(`AIE_OFF_WORK, 32'h1);
    exec({`AIE_OP_ADD_WORK, 1'b1, `AIE_F_PCL});
    rd(`AIE_OFF_PC, 32'h0F1);
    exec({`AIE_OP_BRANCH, 9'h155});
    rd(`AIE_OFF_PC, 32'h155);
    repeat (2) @(posedge pclk);
    chk(33'(q.size()), 33'd0);
    end_sim();
  end
endmodule
